// File: design/sleep_exec.sv
// Execution of the power-down entry instruction and of subtract file from W with borrow.
// Assumes the register file, watchdog and wake sources run on ref_clk; file_rdata is combinational from file_req.addr.
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module sleep_exec
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output sleep_exec_pkg::file_req_s file_req,
	input wire logic [7:0] file_rdata,
	input wire logic [11:0] index_base,
	input wire logic wake_watchdog,
	input wire logic wake_event,
	output logic watchdog_clear,
	output logic osc_halt
);
	sleep_exec_pkg::core_state_s r;
	sleep_exec_pkg::core_state_s next_r;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				m[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic is_subtract_borrow(input logic [15:0] op);
		return op[sleep_exec_pkg::OPC_HI:sleep_exec_pkg::OPC_LO] == sleep_exec_pkg::SUBTRACT_FILE_FROM_WREG_BORROW_OP;
	endfunction

	function automatic logic is_sleep(input logic [15:0] op);
		return op == sleep_exec_pkg::OPC_SLEEP;
	endfunction

	function automatic logic [11:0] eff_addr(input logic [15:0] op, input logic ext, input logic [3:0] bank,
		input logic [11:0] base);
		logic [7:0] f;
		f = op[sleep_exec_pkg::F_HI:0];
		if (op[sleep_exec_pkg::A_BIT])
		begin
			return {bank, f};
		end
		else if (ext && f <= sleep_exec_pkg::ACCESS_LIMIT)
		begin
			return base + {4'h0, f};
		end
		else if (f <= sleep_exec_pkg::ACCESS_LIMIT)
		begin
			return {sleep_exec_pkg::ACCESS_LO_BANK, f};
		end
		return {sleep_exec_pkg::ACCESS_HI_BANK, f};
	endfunction

	always_comb
	begin
		logic [31:0] rword;
		logic [31:0] wword;
		logic [8:0] diff;
		logic [4:0] diff_lo;
		rword = sleep_exec_pkg::READ_ZERO;
		wword = sleep_exec_pkg::READ_ZERO;
		diff = 9'h000;
		diff_lo = 5'h00;
		next_r = r;
		next_r.watchdog_clear = 1'b0;
		next_r.waitrequest = 1'b1;

		case (address)
			sleep_exec_pkg::OFS_CTRL:
				rword[sleep_exec_pkg::CTRL_EXT] = r.ext_en;
			sleep_exec_pkg::OFS_INSTR:
				rword[15:0] = r.op;
			sleep_exec_pkg::OFS_WREG:
				rword[7:0] = r.w;
			sleep_exec_pkg::OFS_BANK_SELECT:
				rword[3:0] = r.bank_select_reg;
			sleep_exec_pkg::OFS_STATUS:
			begin
				rword[sleep_exec_pkg::ST_C] = r.flags.c;
				rword[sleep_exec_pkg::ST_DIGIT_CARRY] = r.flags.digit_carry_flag;
				rword[sleep_exec_pkg::ST_Z] = r.flags.z;
				rword[sleep_exec_pkg::ST_OVERFLOW] = r.flags.overflow_flag;
				rword[sleep_exec_pkg::ST_N] = r.flags.n;
				rword[sleep_exec_pkg::ST_POWER_DOWN] = r.power_down_status_flag;
				rword[sleep_exec_pkg::ST_TIMEOUT] = r.timeout_status_flag;
				rword[sleep_exec_pkg::ST_SLEEPING] = r.state == sleep_exec_pkg::ST_SLEEP;
				rword[sleep_exec_pkg::ST_BUSY] = r.state != sleep_exec_pkg::ST_IDLE;
			end
			default:
				rword = sleep_exec_pkg::READ_ZERO;
		endcase

		// The answer comes one cycle after the request so that waitrequest can be a flop.
		if ((read || write) && r.waitrequest)
		begin
			next_r.waitrequest = 1'b0;
			next_r.readdata = rword;
		end

		if (write && !r.waitrequest)
		begin
			case (address)
				sleep_exec_pkg::OFS_CTRL:
				begin
					wword = be_merge({31'h0, r.ext_en}, writedata, byteenable);
					next_r.ext_en = wword[sleep_exec_pkg::CTRL_EXT];
				end
				sleep_exec_pkg::OFS_INSTR:
				begin
					// An opcode written while busy or asleep is dropped rather than queued.
					if (r.state == sleep_exec_pkg::ST_IDLE)
					begin
						wword = be_merge({16'h0, r.op}, writedata, byteenable);
						next_r.op = wword[15:0];
						next_r.state = sleep_exec_pkg::ST_Q1;
					end
				end
				sleep_exec_pkg::OFS_WREG:
				begin
					wword = be_merge({24'h0, r.w}, writedata, byteenable);
					next_r.w = wword[7:0];
				end
				sleep_exec_pkg::OFS_BANK_SELECT:
				begin
					wword = be_merge({28'h0, r.bank_select_reg}, writedata, byteenable);
					next_r.bank_select_reg = wword[3:0];
				end
				sleep_exec_pkg::OFS_STATUS:
				begin
					wword = be_merge({27'h0, r.flags}, writedata, byteenable);
					next_r.flags = wword[4:0];
				end
				default:
					next_r.ext_en = r.ext_en;
			endcase
		end

		case (r.state)
			sleep_exec_pkg::ST_Q1:
			begin
				next_r.state = sleep_exec_pkg::ST_Q2;
				if (is_subtract_borrow(r.op))
				begin
					next_r.file_req.addr = eff_addr(r.op, r.ext_en, r.bank_select_reg, index_base);
					next_r.file_req.rd_en = 1'b1;
				end
			end
			sleep_exec_pkg::ST_Q2:
			begin
				next_r.state = sleep_exec_pkg::ST_Q3;
				next_r.file_req.rd_en = 1'b0;
				next_r.opnd = file_rdata;
			end
			sleep_exec_pkg::ST_Q3:
			begin
				next_r.state = sleep_exec_pkg::ST_Q4;
				if (is_subtract_borrow(r.op))
				begin
					diff = {1'b0, r.w} - {1'b0, r.opnd} - {8'h00, ~r.flags.c};
					diff_lo = {1'b0, r.w[3:0]} - {1'b0, r.opnd[3:0]} - {4'h0, ~r.flags.c};
					next_r.flags.c = ~diff[8];
					next_r.flags.digit_carry_flag = ~diff_lo[4];
					next_r.flags.z = diff[7:0] == 8'h00;
					next_r.flags.n = diff[7];
					next_r.flags.overflow_flag = (r.w[7] != r.opnd[7]) && (diff[7] != r.w[7]);
					if (r.op[sleep_exec_pkg::D_BIT])
					begin
						next_r.file_req.we = 1'b1;
						next_r.file_req.wdata = diff[7:0];
					end
					else
					begin
						next_r.w = diff[7:0];
					end
				end
				else if (is_sleep(r.op))
				begin
					next_r.power_down_status_flag = 1'b0;
					next_r.timeout_status_flag = 1'b1;
					next_r.watchdog_clear = 1'b1;
					next_r.osc_halt = 1'b1;
				end
			end
			sleep_exec_pkg::ST_Q4:
			begin
				next_r.file_req.we = 1'b0;
				next_r.state = r.osc_halt ? sleep_exec_pkg::ST_SLEEP : sleep_exec_pkg::ST_IDLE;
			end
			sleep_exec_pkg::ST_SLEEP:
			begin
				if (wake_watchdog)
				begin
					next_r.timeout_status_flag = 1'b0;
					next_r.osc_halt = 1'b0;
					next_r.state = sleep_exec_pkg::ST_IDLE;
				end
				else if (wake_event)
				begin
					next_r.osc_halt = 1'b0;
					next_r.state = sleep_exec_pkg::ST_IDLE;
				end
			end
			// Idle must not touch the state, or an opcode written this cycle would never start.
			sleep_exec_pkg::ST_IDLE:
				next_r.file_req.rd_en = 1'b0;
			default:
				next_r.state = sleep_exec_pkg::ST_IDLE;
		endcase

		if (rst)
		begin
			next_r = '0;
			next_r.state = sleep_exec_pkg::ST_IDLE;
			next_r.op = sleep_exec_pkg::INSTR_RESET;
			next_r.w = sleep_exec_pkg::WREG_RESET;
			next_r.bank_select_reg = sleep_exec_pkg::BANK_SELECT_RESET;
			next_r.ext_en = sleep_exec_pkg::EXT_RESET;
			next_r.power_down_status_flag = sleep_exec_pkg::POWER_DOWN_RESET;
			next_r.timeout_status_flag = sleep_exec_pkg::TIMEOUT_RESET;
			next_r.waitrequest = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		r <= next_r;
	end

	assign readdata = r.readdata;
	assign waitrequest = r.waitrequest;
	assign file_req = r.file_req;
	assign watchdog_clear = r.watchdog_clear;
	assign osc_halt = r.osc_halt;
endmodule

// File: design/sleep_exec_pkg.sv
// Constants, types and register map for the sleep and subtract-with-borrow execution block.
// Assumes a single 25 MHz core clock and an Avalon-MM master with 32-bit data.
package sleep_exec_pkg;
	// Opcodes and instruction fields.
	localparam logic [15:0] OPC_SLEEP = 16'h0003;
	localparam logic [5:0] SUBTRACT_FILE_FROM_WREG_BORROW_OP = 6'h15;
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 10;
	localparam int D_BIT = 9;
	localparam int A_BIT = 8;
	localparam int F_HI = 7;
	// Access bank and indexed literal offset window.
	localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	// Byte offsets of the registers.
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_INSTR = 5'h04;
	localparam logic [4:0] OFS_WREG = 5'h08;
	localparam logic [4:0] OFS_BANK_SELECT = 5'h0c;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	// Field positions.
	localparam int CTRL_EXT = 0;
	localparam int ST_C = 0;
	localparam int ST_DIGIT_CARRY = 1;
	localparam int ST_Z = 2;
	localparam int ST_OVERFLOW = 3;
	localparam int ST_N = 4;
	localparam int ST_POWER_DOWN = 5;
	localparam int ST_TIMEOUT = 6;
	localparam int ST_SLEEPING = 7;
	localparam int ST_BUSY = 8;
	// Reset values.
	localparam logic POWER_DOWN_RESET = 1'b1;
	localparam logic TIMEOUT_RESET = 1'b1;
	localparam logic EXT_RESET = 1'b0;
	localparam logic [7:0] WREG_RESET = 8'h00;
	localparam logic [3:0] BANK_SELECT_RESET = 4'h0;
	localparam logic [15:0] INSTR_RESET = 16'h0000;
	localparam logic [31:0] READ_ZERO = 32'h00000000;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_Q1 = 6'h02,
		ST_Q2 = 6'h04,
		ST_Q3 = 6'h08,
		ST_Q4 = 6'h10,
		ST_SLEEP = 6'h20
	} state_e;
	typedef struct packed {
		logic [11:0] addr;
		logic rd_en;
		logic we;
		logic [7:0] wdata;
	} file_req_s;
	typedef struct packed {
		logic n;
		logic overflow_flag;
		logic z;
		logic digit_carry_flag;
		logic c;
	} alu_flags_s;
	typedef struct packed {
		state_e state;
		logic [15:0] op;
		logic [7:0] w;
		logic [3:0] bank_select_reg;
		logic ext_en;
		alu_flags_s flags;
		logic power_down_status_flag;
		logic timeout_status_flag;
		logic [7:0] opnd;
		file_req_s file_req;
		logic watchdog_clear;
		logic osc_halt;
		logic waitrequest;
		logic [31:0] readdata;
	} core_state_s;
endpackage

// File: tb/sleep_exec_assertions.sv
// Port checker for sleep_exec, bound onto the design.
// Assumes one clock ref_clk and the synchronous active-high rst.
`timescale 1ns/1ns
module sleep_exec_assertions
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire sleep_exec_pkg::file_req_s file_req,
	input wire logic wake_watchdog,
	input wire logic wake_event,
	input wire logic watchdog_clear,
	input wire logic osc_halt
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered next cycle");
	wait_single_a: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	clear_pulse_a: assert property (watchdog_clear |=> !watchdog_clear)
		else $error("watchdog clear not a pulse");
	halt_cause_a: assert property ($rose(osc_halt) |-> watchdog_clear)
		else $error("halt without power-down entry");
	clear_halts_a: assert property (watchdog_clear |-> osc_halt ##1 osc_halt)
		else $error("oscillator not halted in last quarter");
	read_pulse_a: assert property (file_req.rd_en |=> !file_req.rd_en)
		else $error("file read not a pulse");
	write_order_a: assert property (file_req.we |-> $past(file_req.rd_en, 2) && $stable(file_req.addr))
		else $error("file write not two cycles after read");
	wake_resume_a: assert property (osc_halt && !watchdog_clear && (wake_watchdog || wake_event) |=> !osc_halt)
		else $error("no resume on wake");
	sleep_quiet_a: assert property (watchdog_clear |-> !file_req.rd_en && !file_req.we)
		else $error("file access during power-down entry");
endmodule
bind sleep_exec sleep_exec_assertions chk_i (.ref_clk(ref_clk), .rst(rst), .read(read), .write(write),
	.waitrequest(waitrequest), .file_req(file_req), .wake_watchdog(wake_watchdog), .wake_event(wake_event),
	.watchdog_clear(watchdog_clear), .osc_halt(osc_halt));

// File: tb/sleep_exec_bench.sv
// Self-checking bench for sleep_exec with random subtract operands.
// Assumes the bench plays bus master, register file and wake sources.
`timescale 1ns/1ns
module sleep_exec_bench;
	logic ref_clk, rst, read, write, waitrequest, watchdog_clear, osc_halt, wake_watchdog, wake_event, dd, aa, cc, ee;
	logic [4:0] address, fl;
	logic [31:0] writedata, readdata, q, st;
	logic [3:0] byteenable, bs;
	logic [7:0] file_rdata, w, f, fa, res;
	logic [11:0] index_base, ea;
	sleep_exec_pkg::file_req_s file_req, last_wr;
	int fails, comparisons, wdc, wrc, i, j, n;
	sleep_exec dut (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.file_req(file_req), .file_rdata(file_rdata), .index_base(index_base), .wake_watchdog(wake_watchdog),
		.wake_event(wake_event), .watchdog_clear(watchdog_clear), .osc_halt(osc_halt));
	initial
	begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		if (file_req.we === 1'b1) last_wr <= file_req;
		if (file_req.we === 1'b1) wrc <= wrc + 1;
		if (watchdog_clear === 1'b1) wdc <= wdc + 1;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task give_verdict;
		if (fails == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// The request stays up until waitrequest is seen low, then one idle edge keeps strobes single-driven.
	task bus(input logic [4:0] a, input logic wr, input logic [31:0] d, output logic [31:0] o);
		int k;
		k = 0;
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		do begin @(posedge ref_clk); k++; end while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50) begin fails++; give_verdict; end
		o = readdata;
		read <= 0;
		write <= 0;
		@(posedge ref_clk);
	endtask
	function automatic logic [12:0] sub_exp(input logic [7:0] a, input logic [7:0] b, input logic c);
		logic [8:0] d9;
		logic [4:0] d5;
		d9 = {1'b0, a} - {1'b0, b} - {8'h00, !c};
		d5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, !c};
		return {d9[7], (a[7] != b[7]) && (d9[7] != a[7]), d9[7:0] == 8'h00, !d5[4], !d9[8], d9[7:0]};
	endfunction
	function automatic logic [11:0] addr_exp(input logic a, input logic e, input logic [7:0] b, input logic [3:0] k,
		input logic [11:0] base);
		if (a) return {k, b};
		if (b <= 8'h5f) return e ? base + {4'h0, b} : {4'h0, b};
		return {4'hf, b};
	endfunction
	initial
	begin
		{rst, read, write, wake_watchdog, wake_event} = 5'h10;
		{address, writedata, file_rdata, index_base} = 0;
		byteenable = 4'hf;
		{fails, comparisons, wdc, wrc} = 0;
		void'($urandom(9));
		repeat (12) @(posedge ref_clk);
		rst <= 0;
		@(posedge ref_clk);
		bus(sleep_exec_pkg::OFS_STATUS, 0, 0, q);
		chk(q, 32'h60);
		bus(5'h14, 0, 0, q);
		chk(q, 32'h0);
		for (i = 0; i < 2; i++)
		begin
			bus(sleep_exec_pkg::OFS_INSTR, 1, 32'h3, q);
			repeat (6) @(posedge ref_clk);
			bus(sleep_exec_pkg::OFS_STATUS, 0, 0, q);
			// Asleep counts as busy, so bits 6, 7 and 8 are all set here.
			chk(q & 32'h1e0, 32'h1c0);
			chk(32'(wdc), 32'(i + 1));
			chk({31'h0, osc_halt}, 32'h1);
			if (i == 0) wake_watchdog <= 1; else wake_event <= 1;
			@(posedge ref_clk);
			{wake_watchdog, wake_event} <= 2'h0;
			repeat (2) @(posedge ref_clk);
			chk({31'h0, osc_halt}, 32'h0);
			bus(sleep_exec_pkg::OFS_STATUS, 0, 0, q);
			chk(q & 32'h1e0, i ? 32'h40 : 32'h0);
		end
		for (i = 0; i < 40; i++)
		begin
			{w, f, fa, dd, aa, cc, ee, bs} = $urandom;
			if (i < 4) {fa, aa, ee} = {8'h5e + 8'(i), 2'h1};
			if (i == 4) {w, f, cc} = {16'h8001, 1'b1};
			if (i == 5) {w, f, cc} = {16'h0502, 1'b1};
			file_rdata <= f;
			index_base <= 12'($urandom);
			bus(sleep_exec_pkg::OFS_CTRL, 1, {31'h0, ee}, q);
			bus(sleep_exec_pkg::OFS_BANK_SELECT, 1, {28'h0, bs}, q);
			bus(sleep_exec_pkg::OFS_WREG, 1, {24'h0, w}, q);
			bus(sleep_exec_pkg::OFS_STATUS, 1, {31'h0, cc}, q);
			n = wrc;
			bus(sleep_exec_pkg::OFS_INSTR, 1,
				{16'h0, sleep_exec_pkg::SUBTRACT_FILE_FROM_WREG_BORROW_OP, dd, aa, fa}, q);
			j = 0;
			do
			begin
				bus(sleep_exec_pkg::OFS_STATUS, 0, 0, st);
				j++;
			end
			while (st[8] !== 1'b0 && j < 20);
			if (j >= 20) begin fails++; give_verdict; end
			{fl, res} = sub_exp(w, f, cc);
			ea = addr_exp(aa, ee, fa, bs, index_base);
			chk({20'h0, file_req.addr}, {20'h0, ea});
			chk(st & 32'h1f, {27'h0, fl});
			bus(sleep_exec_pkg::OFS_WREG, 0, 0, q);
			chk(q, {24'h0, dd ? w : res});
			chk(32'(wrc - n), {31'h0, dd});
			if (dd) chk({12'h0, last_wr.addr, last_wr.wdata}, {12'h0, ea, res});
		end
		give_verdict;
	end
endmodule
